// ===== rtl/smrlc_pin_mux.sv
module smrlc_pin_mux (
  input  wire logic [1:0]  bus_width_sel_i,
  input  wire logic        lane_access_type_i,
  input  wire logic [25:0] addr_i,
  input  wire logic [3:0]  lanes_i,
  input  wire logic        lanes_act_i,
  input  wire logic        wr_act_i,
  output logic [25:0]      addr_pins_o,
  output logic [3:0]       lane_pin_n_o
);
  logic w8;
  logic w16;
  logic bsel;
  logic [3:0] sel_n;
  logic [3:0] wr_n;

  assign w8   = (bus_width_sel_i == smrlc_pkg::WIDTH_8);
  assign w16  = (bus_width_sel_i == smrlc_pkg::WIDTH_16);
  assign bsel = w8 || (lane_access_type_i == smrlc_pkg::ACC_SELECT);

  // ----------------------------------------------------------------
  // lane strobes
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign sel_n[g] = ~(lanes_act_i & lanes_i[g]);
      assign wr_n[g]  = ~(wr_act_i & lanes_i[g]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin multiplexing
  // ----------------------------------------------------------------
  always_comb begin
    addr_pins_o       = {addr_i[25:2], 2'h0};
    lane_pin_n_o      = 4'hF;
    if (w8) begin
      addr_pins_o[1:0] = addr_i[1:0];
    end else if (w16) begin
      addr_pins_o[1]   = addr_i[1];
      // two lane selects or writes on 16 bit
      lane_pin_n_o[1:0] = bsel ? sel_n[1:0] : wr_n[1:0];
    end else begin
      // four lane selects or writes on 32 bit
      lane_pin_n_o = bsel ? sel_n : wr_n;
    end
  end
endmodule

// ===== rtl/smrlc_pkg.sv
package smrlc_pkg;
  localparam int unsigned NUM_CS     = 6;
  localparam int unsigned ADDR_W     = 26;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned SETUP_W    = 6;
  localparam int unsigned PULSE_W    = 7;
  localparam int unsigned CYCLE_W    = 9;
  localparam int unsigned CNT_W      = 10;
  // bus width field encoding
  localparam logic [1:0]  WIDTH_8    = 2'h0;
  localparam logic [1:0]  WIDTH_16   = 2'h1;
  localparam logic [1:0]  WIDTH_32   = 2'h2;
  // lane access type encoding
  localparam logic        ACC_SELECT = 1'h0;
  localparam logic        ACC_WRITE  = 1'h1;
  // read mode: which strobe marks valid data
  localparam logic        RMODE_CS   = 1'h0;
  localparam logic        RMODE_RD   = 1'h1;
endpackage

// ===== rtl/smrlc_read_ctrl.sv
// How it works
// - drive 26-bit address, 64-Mbyte window per chip select
// - small devices repeat through window; upper bits ignored
// - significant address bits start at 0, 1 or 2 by width
// - per chip select width of 8, 16 or 32 bits
// - 16/32-bit chip selects use byte-write or byte-select
// - 16-bit byte-write: two lane write strobes, one read strobe
// - 32-bit byte-write: four lane write strobes, one read strobe
// - byte-select: one select per lane, single read and write strobe
// - booting from a byte-write chip select is refused
// - shared pins muxed by width and access type
// - 32-bit drops two low address bits, 16-bit drops bit 0
// - unused lane writes or selects stay idle
// - lane selects time exactly like the address
// - lane write strobes time like the single write strobe
// - address driven first, stable until cycle length ends
// - read strobe falls after setup, low for pulse, then hold
// - chip select has own setup and pulse, hold is remainder
// - read timings per chip select in clocks, shared cycle length
// - hold never programmed; derived from cycle minus setup, pulse
// - zero setup and hold keeps strobes low across reads
// - per chip select mode picks which strobe marks data valid
// - six chip selects share one address bus
// - all selects and strobes active low
// - read strobe mode samples data on its rising-edge clock
module smrlc_read_ctrl #(
  parameter int unsigned NUM_CS = smrlc_pkg::NUM_CS
) (
  input  wire logic                                    clk_i,
  input  wire logic                                    rst_i,
  // request side
  input  wire logic                                    req_valid_i,
  output logic                                         req_ready_o,
  input  wire logic [$clog2(NUM_CS)-1:0]               req_cs_i,
  input  wire logic [25:0]                             req_addr_i,
  input  wire logic [3:0]                              req_lanes_i,
  input  wire logic                                    boot_i,
  output logic                                         req_refused_o,
  // per chip select configuration
  input  wire logic [NUM_CS-1:0][1:0]                  bus_width_sel_i,
  input  wire logic [NUM_CS-1:0]                       lane_access_type_i,
  input  wire logic [NUM_CS-1:0]                       read_mode_i,
  input  wire logic [NUM_CS-1:0][smrlc_pkg::SETUP_W-1:0] rd_strobe_setup_i,
  input  wire logic [NUM_CS-1:0][smrlc_pkg::PULSE_W-1:0] rd_strobe_pulse_i,
  input  wire logic [NUM_CS-1:0][smrlc_pkg::SETUP_W-1:0] rd_select_setup_i,
  input  wire logic [NUM_CS-1:0][smrlc_pkg::PULSE_W-1:0] rd_select_pulse_i,
  input  wire logic [NUM_CS-1:0][smrlc_pkg::CYCLE_W-1:0] read_cycle_len_i,
  // data answer
  output logic [31:0]                                  rd_data_o,
  output logic                                         rd_data_valid_o,
  // memory pins
  output logic [25:0]                                  addr_o,
  output logic [NUM_CS-1:0]                            mem_select_n_o,
  output logic                                         read_strobe_n_o,
  output logic                                         write_strobe_n_o,
  output logic [3:0]                                   lane_pin_n_o,
  input  wire logic [31:0]                             data_i,
  output logic [31:0]                                  data_o,
  output logic [31:0]                                  data_oe_o
);
  localparam int CW = smrlc_pkg::CNT_W;

  typedef enum logic [0:0] {SMRLC_IDLE, SMRLC_READ} smrlc_state_t;

  smrlc_state_t                state_r;
  logic [$clog2(NUM_CS)-1:0]   cs_r;
  logic [25:0]                 addr_r;
  logic [3:0]                  lanes_r;
  logic [CW-1:0]               cnt_r;
  logic [CW-1:0]               cnt_nxt;
  logic                        rd_low_r;
  logic                        cs_low_r;
  logic [31:0]                 rd_data_r;
  logic                        rd_data_valid_r;
  logic                        refused_r;

  logic [CW-1:0] cyc;
  logic [CW-1:0] rs_on;
  logic [CW-1:0] rs_off;
  logic [CW-1:0] cs_on;
  logic [CW-1:0] cs_off;
  logic          last;
  logic          take;
  logic          bad_boot;
  logic          rd_low_nxt;
  logic          cs_low_nxt;
  logic [1:0]    width_cur;
  logic          acc_cur;
  logic [25:0]   addr_fmt;

  // ----------------------------------------------------------------
  // timing decode for the active chip select
  // ----------------------------------------------------------------
  // per chip select counts in clocks
  assign cyc    = CW'(read_cycle_len_i[cs_r]);
  assign rs_on  = CW'(rd_strobe_setup_i[cs_r]);
  assign cs_on  = CW'(rd_select_setup_i[cs_r]);
  // hold is the remainder of the cycle
  assign rs_off = rs_on + CW'(rd_strobe_pulse_i[cs_r]);
  assign cs_off = cs_on + CW'(rd_select_pulse_i[cs_r]);
  assign last   = (state_r == SMRLC_READ) && (cnt_r + CW'(1) >= cyc);

  // no boot from byte-write chip select
  assign bad_boot = boot_i && (bus_width_sel_i[req_cs_i] != smrlc_pkg::WIDTH_8)
                    && (lane_access_type_i[req_cs_i] == smrlc_pkg::ACC_WRITE);
  assign req_ready_o = (state_r == SMRLC_IDLE) || last;
  assign take        = req_valid_i && req_ready_o && !bad_boot;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r + CW'(1);
    if (take) begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= SMRLC_IDLE;
      cnt_r   <= '0;
    end else begin
      unique case (state_r)
        SMRLC_IDLE: begin
          if (take) begin
            state_r <= SMRLC_READ;
          end
          cnt_r <= '0;
        end
        SMRLC_READ: begin
          if (last && !take) begin
            state_r <= SMRLC_IDLE;
          end
          cnt_r <= cnt_nxt;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_r    <= '0;
      addr_r  <= '0;
      lanes_r <= 4'h0;
    end else if (take) begin
      cs_r    <= req_cs_i;
      // upper bits simply ignored by device
      addr_r  <= req_addr_i;
      lanes_r <= req_lanes_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused_r <= 1'h0;
    end else begin
      refused_r <= req_valid_i && req_ready_o && bad_boot;
    end
  end

  // ----------------------------------------------------------------
  // strobe waveforms
  // ----------------------------------------------------------------
  // next-count strobe levels; registered so pins are glitch free
  always_comb begin
    logic [CW-1:0] n;
    n          = take ? '0 : cnt_nxt;
    rd_low_nxt = 1'h0;
    cs_low_nxt = 1'h0;
    if (take || (state_r == SMRLC_READ && !last)) begin
      if (take) begin
        // new cycle uses the incoming chip select's counts
        rd_low_nxt = (CW'(rd_strobe_setup_i[req_cs_i]) == '0);
        cs_low_nxt = (CW'(rd_select_setup_i[req_cs_i]) == '0);
      end else begin
        // strobe low from setup for pulse
        rd_low_nxt = (n >= rs_on) && (n < rs_off);
        cs_low_nxt = (n >= cs_on) && (n < cs_off);
      end
    end
  end

  // zero setup and hold stays low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_low_r <= 1'h0;
      cs_low_r <= 1'h0;
    end else begin
      rd_low_r <= rd_low_nxt;
      cs_low_r <= cs_low_nxt;
    end
  end

  // ----------------------------------------------------------------
  // data capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_r       <= 32'h0000_0000;
      rd_data_valid_r <= 1'h0;
    end else begin
      rd_data_valid_r <= 1'h0;
      if (read_mode_i[cs_r] == smrlc_pkg::RMODE_RD) begin
        if (rd_low_r && !rd_low_nxt) begin
          rd_data_r       <= data_i;
          rd_data_valid_r <= 1'h1;
        end
      end else if (cs_low_r && !cs_low_nxt) begin
        rd_data_r       <= data_i;
        rd_data_valid_r <= 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // width per chip select
  assign width_cur = bus_width_sel_i[cs_r];
  assign acc_cur   = lane_access_type_i[cs_r];

  always_comb begin
    addr_fmt = addr_r;
    if (width_cur == smrlc_pkg::WIDTH_16) begin
      addr_fmt[0] = 1'h0;
    end else if (width_cur != smrlc_pkg::WIDTH_8) begin
      addr_fmt[1:0] = 2'h0;
    end
  end

  smrlc_pin_mux u_mux (
    .bus_width_sel_i    (width_cur),
    .lane_access_type_i (acc_cur),
    .addr_i             (addr_fmt),
    .lanes_i            (lanes_r),
    .lanes_act_i        (state_r == SMRLC_READ),
    .wr_act_i           (1'h0),
    .addr_pins_o        (addr_o),
    .lane_pin_n_o       (lane_pin_n_o)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_CS; g++) begin : g_cs
      assign mem_select_n_o[g] = ~(cs_low_r && (cs_r == g));
    end
  endgenerate

  assign read_strobe_n_o  = ~rd_low_r;
  assign write_strobe_n_o = 1'h1;
  assign data_o           = 32'h0000_0000;
  assign data_oe_o        = 32'h0000_0000;
  assign rd_data_o        = rd_data_r;
  assign rd_data_valid_o  = rd_data_valid_r;
  assign req_refused_o    = refused_r;
endmodule

// ===== tb/smrlc_mem_model.sv
module smrlc_mem_model (
  input  wire logic        clk_i,
  input  wire logic [25:0] addr_i,
  input  wire logic [5:0]  sel_n_i,
  input  wire logic        rd_n_i,
  output logic [31:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_r;
  // released bus shows inverse of last value, so a stale sample is caught
  assign data_o = (!rd_n_i || !(&sel_n_i)) ? ({6'h00, addr_i} ^ 32'h5A000000) : ~last_r;
  // remember only driven words, so the released bus holds one steady inverse
  always_ff @(posedge clk_i) begin
    if (!rd_n_i || !(&sel_n_i)) begin
      last_r <= data_o;
    end
  end
endmodule

// ===== tb/smrlc_read_ctrl_chk.sv
module smrlc_read_ctrl_chk #(
  parameter int unsigned NUM_CS = smrlc_pkg::NUM_CS
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              req_valid_i,
  input wire logic              req_ready_o,
  input wire logic              boot_i,
  input wire logic              req_refused_o,
  input wire logic              rd_data_valid_o,
  input wire logic [25:0]       addr_o,
  input wire logic [NUM_CS-1:0] mem_select_n_o,
  input wire logic              read_strobe_n_o,
  input wire logic              write_strobe_n_o,
  input wire logic [3:0]        lane_pin_n_o,
  input wire logic [31:0]       data_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_write_strobe_idle: assert property (write_strobe_n_o)
    else $error("write strobe low in read");
  a_data_bus_float: assert property (data_oe_o == 32'h0)
    else $error("data bus driven");
  a_single_select: assert property ($onehot0(~mem_select_n_o))
    else $error("several selects low");
  a_refuse_cause: assert property (req_refused_o |-> $past(req_valid_i && boot_i && req_ready_o))
    else $error("refusal without boot request");
  a_refuse_no_cycle: assert property (req_refused_o |-> &mem_select_n_o && read_strobe_n_o)
    else $error("refused request started a cycle");
  a_addr_held: assert property (!req_ready_o |=> $stable(addr_o))
    else $error("address moved in cycle");
  a_lanes_held: assert property (!req_ready_o |=> $stable(lane_pin_n_o))
    else $error("lane pins moved in cycle");
  a_reset_idle: assert property ($past(rst_i) |-> &mem_select_n_o && read_strobe_n_o && &lane_pin_n_o)
    else $error("pins not idle after reset");
  c_refused: cover property (req_refused_o);
  c_valid: cover property (rd_data_valid_o);
  c_back_to_back: cover property (!read_strobe_n_o && req_ready_o && req_valid_i);
endmodule

bind smrlc_read_ctrl smrlc_read_ctrl_chk #(.NUM_CS(NUM_CS)) u_chk (.clk_i, .rst_i, .req_valid_i, .req_ready_o,
  .boot_i, .req_refused_o, .rd_data_valid_o, .addr_o, .mem_select_n_o, .read_strobe_n_o, .write_strobe_n_o,
  .lane_pin_n_o, .data_oe_o);

// ===== tb/smrlc_read_ctrl_tb.sv
module smrlc_read_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned N = smrlc_pkg::NUM_CS;
  logic                                 clk_i, rst_i, req_valid_i, boot_i, req_ready_o, req_refused_o;
  logic                                 rd_data_valid_o, read_strobe_n_o, write_strobe_n_o;
  logic [2:0]                           req_cs_i;
  logic [25:0]                          req_addr_i, addr_o;
  logic [3:0]                           req_lanes_i, lane_pin_n_o;
  logic [N-1:0][1:0]                    bus_width_sel_i;
  logic [N-1:0]                         lane_access_type_i, read_mode_i, mem_select_n_o;
  logic [N-1:0][smrlc_pkg::SETUP_W-1:0] rd_strobe_setup_i, rd_select_setup_i;
  logic [N-1:0][smrlc_pkg::PULSE_W-1:0] rd_strobe_pulse_i, rd_select_pulse_i;
  logic [N-1:0][smrlc_pkg::CYCLE_W-1:0] read_cycle_len_i;
  logic [31:0]                          rd_data_o, data_i, data_o, data_oe_o;
  int                                   error_cnt, checks;
  smrlc_read_ctrl dut (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_cs_i, .req_addr_i, .req_lanes_i, .boot_i,
    .req_refused_o, .bus_width_sel_i, .lane_access_type_i, .read_mode_i, .rd_strobe_setup_i, .rd_strobe_pulse_i,
    .rd_select_setup_i, .rd_select_pulse_i, .read_cycle_len_i, .rd_data_o, .rd_data_valid_o, .addr_o,
    .mem_select_n_o, .read_strobe_n_o, .write_strobe_n_o, .lane_pin_n_o, .data_i, .data_o, .data_oe_o);
  smrlc_mem_model u_mem (.clk_i, .addr_i(addr_o), .sel_n_i(mem_select_n_o), .rd_n_i(read_strobe_n_o), .data_o(data_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [25:0] exp_addr(input logic [1:0] w, input logic [25:0] a);
    return (w == smrlc_pkg::WIDTH_32) ? {a[25:2], 2'h0} : (w == smrlc_pkg::WIDTH_16) ? {a[25:1], 1'h0} : a;
  endfunction
  function automatic logic [3:0] exp_lane(input logic [1:0] w, input logic t, input logic [3:0] l);
    if (w == smrlc_pkg::WIDTH_8 || t == smrlc_pkg::ACC_WRITE)
      return 4'hF;
    return (w == smrlc_pkg::WIDTH_16) ? {2'h3, ~l[1:0]} : ~l;
  endfunction
  // --------------------------------
  // stimulus
  // --------------------------------
  task automatic rand_cfg();
    int ss, sp, cs, cp;
    for (int i = 0; i < N; i++) begin
      ss = $urandom_range(3);
      cs = $urandom_range(3);
      sp = $urandom_range(4, 1);
      cp = $urandom_range(4, 1);
      bus_width_sel_i[i] = 2'($urandom_range(2));
      lane_access_type_i[i] = 1'($urandom);
      read_mode_i[i] = 1'($urandom);
      rd_strobe_setup_i[i] = 6'(ss);
      rd_select_setup_i[i] = 6'(cs);
      rd_strobe_pulse_i[i] = 7'(sp);
      rd_select_pulse_i[i] = 7'(cp);
      read_cycle_len_i[i] = 9'(((ss + sp > cs + cp) ? ss + sp : cs + cp) + $urandom_range(2));
    end
  endtask
  task automatic rd(input logic [2:0] c, input logic [25:0] a, input logic [3:0] l, input logic b);
    int ss, sp, cs, cp, cy, n, f_rd, f_cs, lo_rd, lo_cs, v_at;
    logic [1:0] w;
    w = bus_width_sel_i[c];
    ss = rd_strobe_setup_i[c];
    sp = rd_strobe_pulse_i[c];
    cs = rd_select_setup_i[c];
    cp = rd_select_pulse_i[c];
    cy = read_cycle_len_i[c];
    {f_rd, f_cs, lo_rd, lo_cs, v_at, n} = '0;
    {req_cs_i, req_addr_i, req_lanes_i, boot_i, req_valid_i} = {c, a, l, b, 1'b1};
    while (req_ready_o !== 1'b1) begin
      @(negedge clk_i);
      n++;
      if (n > 1000) begin
        error_cnt++;
        test_done();
      end
    end
    @(negedge clk_i);
    req_valid_i = 1'b0;
    if (b && w != smrlc_pkg::WIDTH_8 && lane_access_type_i[c] == smrlc_pkg::ACC_WRITE) begin
      chk(req_refused_o, 1'b1);
      repeat (3) begin
        chk(mem_select_n_o, 6'h3F);
        @(negedge clk_i);
      end
      return;
    end
    for (n = 1; n <= cy + 1; n++) begin
      if (read_strobe_n_o === 1'b0) begin
        f_rd = (f_rd == 0) ? n : f_rd;
        lo_rd++;
      end
      if (mem_select_n_o[c] === 1'b0) begin
        f_cs = (f_cs == 0) ? n : f_cs;
        lo_cs++;
      end
      if (rd_data_valid_o === 1'b1) begin
        v_at = n;
        chk(rd_data_o, {6'h00, exp_addr(w, a)} ^ 32'h5A000000);
      end
      if (n <= cy) begin
        chk(data_o, 32'h0000_0000);
        chk(addr_o, exp_addr(w, a));
        chk(lane_pin_n_o, exp_lane(w, lane_access_type_i[c], l));
      end
      if (n == cy)
        chk(req_ready_o, 1'b1);
      @(negedge clk_i);
    end
    chk(f_rd, ss + 1);
    chk(lo_rd, sp);
    chk(f_cs, cs + 1);
    chk(lo_cs, cp);
    chk(v_at, (read_mode_i[c] == smrlc_pkg::RMODE_RD) ? ss + sp + 1 : cs + cp + 1);
  endtask
  initial begin
    {req_valid_i, boot_i, req_cs_i, req_addr_i, req_lanes_i, error_cnt, checks} = '0;
    rst_i = 1'h1;
    void'($urandom(32'hFE234F13));
    rand_cfg();
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    chk(addr_o, 26'h0);
    // every width and access type, top of the window, boot refusal on byte-write
    for (int c = 0; c < N; c++) begin
      bus_width_sel_i[c] = 2'(c % 3);
      lane_access_type_i[c] = 1'(c / 3);
      rd(3'(c), 26'h3FFFFFF, 4'h5, c > 3);
    end
    for (int k = 0; k < 60; k++) begin
      if (k % 20 == 0)
        rand_cfg();
      rd(3'($urandom_range(5)), 26'($urandom), 4'($urandom), $urandom_range(3) == 0);
    end
    // zero setup and hold: strobes stay low over back-to-back reads
    {rd_strobe_setup_i[0], rd_select_setup_i[0]} = 12'h000;
    {rd_strobe_pulse_i[0], rd_select_pulse_i[0], read_cycle_len_i[0]} = {7'h02, 7'h02, 9'h002};
    {req_cs_i, boot_i, req_valid_i} = {3'h0, 1'b0, 1'b1};
    @(negedge clk_i);
    repeat (6) begin
      chk({read_strobe_n_o, mem_select_n_o[0]}, 2'h0);
      @(negedge clk_i);
    end
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    @(negedge clk_i);
    rst_i = 1'b0;
    chk({mem_select_n_o, read_strobe_n_o, lane_pin_n_o}, 11'h7FF);
    rd(3'h1, 26'h0000001, 4'hF, 1'b0);
    test_done();
  end
endmodule
